// ==== rtl/htr_pkg.sv ====
// Package of constants and types for the humidity/temperature readout host.
// Behaviour
// - Host raises chip select between two accesses.
// - MISO changes after SCK fall, sampled rising.
// - Host holds SCK low two sensor clocks.
// - Host SCK rate stays below 10 MHz.
// - Both ends use SPI mode 0.
// - Host keeps sensor clock 16 cycles after power-down.
// - No readout for 1350 sensor clocks after wake.
// - Sensor clock recommended between 30 and 60 kHz.
// - Temperature converts linearly from raw code.
// - Humidity linearized by quadratic on raw reading.
// - Humidity gets temperature correction away from 25 C.
// - Chip select high at least three sensor clocks.
package htr_pkg;
   // System clock period in ns, 25 MHz.
   localparam int SYS_PERIOD_NS = 40;
   // Sensor clock: 32 kHz gives 390 system clocks per half period.
   localparam int SENS_FREQ_HZ = 32000;
   localparam int SENS_HALF_CYC =
      1000000000 / (SENS_FREQ_HZ * 2 * SYS_PERIOD_NS);
   // Sensor clock counts.
   localparam int CS_SETUP_SENS = 3;
   localparam int CS_GAP_SENS = 3;
   localparam int PD_HOLD_SENS = 16;
   localparam int INIT_SENS = 1350;
   // SCK half period: 200 ns minimum half period keeps rate below 10 MHz.
   localparam int SCK_HALF_NS = 200;
   localparam int SCK_HALF_CYC = (SCK_HALF_NS + SYS_PERIOD_NS - 1)
      / SYS_PERIOD_NS;
   localparam int FRAME_BITS = 16;
   // Temperature in hundredths: code * 10000 / 255 - 2000.
   localparam int TEMP_SCALE_NUM = 10000;
   localparam int TEMP_SCALE_DEN = 255;
   localparam int TEMP_OFFSET_CENTI = 2000;
   // Humidity terms carry a 1e7 scale, so the sum divides by 1e5.
   localparam int HUM_C1_E7 = -128400000;
   localparam int HUM_C2_E7 = 6800000;
   localparam int HUM_C3_E7 = -7981;
   localparam int CORR_REF_CENTI = 2500;
   localparam int CORR_T1_E5 = 1000;
   localparam int CORR_T2_E5 = 75;
   localparam int HUM_DIV_E5 = 100000;

   typedef struct packed {
      logic [7:0] humidity;
      logic [7:0] temperature;
   } htr_sample_s;

   typedef struct packed {
      logic csN;
      logic sck;
      logic powerDownRequest;
      logic sensClk;
   } htr_pins_s;

   typedef struct packed {
      logic [15:0] humidCenti;
      logic [15:0] tempCenti;
   } htr_phys_s;
endpackage : htr_pkg

// ==== rtl/htr_clkdiv.sv ====
// Sensor clock divider that also reports each rising edge it makes.
`timescale 1ns/100ps
`default_nettype none
module htr_clkdiv #(
   parameter int HALF_CYC = 390
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Control
   input wire logic runEn,
   // Outputs
   output logic sensClk,
   output logic sensRise
);
   // The half-period counter is 16 bits wide.
   if (HALF_CYC < 2 || HALF_CYC > 65536) begin : g_bad_half
      $error("HALF_CYC out of range");
   end
   logic [15:0] cnt_reg, cnt_next;
   logic clk_reg, clk_next;
   always_comb begin
      cnt_next = cnt_reg;
      clk_next = clk_reg;
      if (runEn) begin
         if (cnt_reg == 16'(HALF_CYC - 1)) begin
            cnt_next = 16'h0000;
            clk_next = ~clk_reg;
         end else begin
            cnt_next = cnt_reg + 16'h0001;
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cnt_reg <= 16'h0000;
         clk_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         clk_reg <= clk_next;
      end
   end
   assign sensClk = clk_reg;
   assign sensRise = runEn && !clk_reg && cnt_reg == 16'(HALF_CYC - 1);
endmodule : htr_clkdiv
`default_nettype wire

// ==== rtl/htr_host.sv ====
// SPI master that powers, wakes and reads the humidity/temperature sensor.
`timescale 1ns/100ps
`default_nettype none
module htr_host
   import htr_pkg::*;
#(
   parameter int SENS_HALF = htr_pkg::SENS_HALF_CYC,
   parameter int INIT_CNT = htr_pkg::INIT_SENS
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // User control
   input wire logic readReq,
   input wire logic sleepReq,
   output logic busy,
   output logic ready,
   output logic sampleValid,
   output htr_pkg::htr_sample_s sample,
   output htr_pkg::htr_phys_s phys,
   output logic asleep,
   // Sensor pins
   output htr_pkg::htr_pins_s pins,
   input wire logic miso
);
   import htr_pkg::*;

   if (INIT_CNT < 1 || INIT_CNT > 65535) begin : g_bad_init
      $error("INIT_CNT out of range");
   end

   typedef enum logic [2:0] {
      ST_INIT = 3'b000,
      ST_IDLE = 3'b001,
      ST_SETUP = 3'b010,
      ST_LOW = 3'b011,
      ST_HIGH = 3'b100,
      ST_GAP = 3'b101,
      ST_PDHOLD = 3'b110,
      ST_SLEEP = 3'b111
   } htr_state_e;

   htr_state_e state_reg, state_next;
   logic [15:0] sens_reg, sens_next;
   logic [7:0] tick_reg, tick_next;
   logic [4:0] bit_reg, bit_next;
   logic [15:0] shift_reg, shift_next;
   htr_sample_s sample_reg, sample_next;
   logic valid_reg, valid_next;
   logic csN_reg, csN_next;
   logic sck_reg, sck_next;
   logic pd_reg, pd_next;
   logic misoMeta_reg, misoSync_reg;
   logic clkRun;
   logic sensClk, sensRise;
   htr_phys_s phys_reg, phys_next;

   // Results are hundredths; each division truncates toward zero; the divisors are
   // constants, so no run-time divider is built.
   function automatic logic [15:0] temp_centi(input logic [7:0] code);
      int scaled;
      scaled = int'(code) * TEMP_SCALE_NUM / TEMP_SCALE_DEN;
      return 16'(scaled - TEMP_OFFSET_CENTI);
   endfunction : temp_centi

   function automatic logic [15:0] humid_centi(input logic [7:0] raw,
         input logic [15:0] tempC);
      int s;
      int acc;
      s = int'(raw);
      acc = HUM_C1_E7 + HUM_C2_E7 * s + HUM_C3_E7 * s * s;
      acc = acc + (int'(signed'(tempC)) - CORR_REF_CENTI)
         * (CORR_T1_E5 + CORR_T2_E5 * s);
      return 16'(acc / HUM_DIV_E5);
   endfunction : humid_centi

   // Sensor clock stops only in sleep, once the hold count is done.
   assign clkRun = state_reg != ST_SLEEP;

   htr_clkdiv #(.HALF_CYC(SENS_HALF)) uDiv (
      .clk_sys(clk_sys),
      .rst(rst),
      .runEn(clkRun),
      .sensClk(sensClk),
      .sensRise(sensRise)
   );

   // MISO comes from the sensor domain, so it is synchronised first.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         misoMeta_reg <= 1'b0;
         misoSync_reg <= 1'b0;
      end else begin
         misoMeta_reg <= miso;
         misoSync_reg <= misoMeta_reg;
      end
   end

   always_comb begin
      state_next = state_reg;
      sens_next = sens_reg;
      tick_next = tick_reg;
      bit_next = bit_reg;
      shift_next = shift_reg;
      sample_next = sample_reg;
      phys_next = phys_reg;
      valid_next = 1'b0;
      csN_next = csN_reg;
      sck_next = sck_reg;
      pd_next = pd_reg;
      unique case (state_reg)
         ST_INIT: begin
            // Wake-up wait counted in sensor clocks.
            if (sensRise) begin
               if (sens_reg == 16'(INIT_CNT - 1)) begin
                  state_next = ST_IDLE;
                  sens_next = 16'h0000;
               end else begin
                  sens_next = sens_reg + 16'h0001;
               end
            end
         end
         ST_IDLE: begin
            if (sleepReq) begin
               pd_next = 1'b1;
               state_next = ST_PDHOLD;
               sens_next = 16'h0000;
            end else if (readReq) begin
               csN_next = 1'b0;
               state_next = ST_SETUP;
               sens_next = 16'h0000;
               bit_next = 5'h00;
            end
         end
         ST_SETUP: begin
            // SCK stays low; wait past two sensor clocks for the MSB.
            sck_next = 1'b0;
            if (sensRise) begin
               if (sens_reg == 16'(CS_SETUP_SENS - 1)) begin
                  state_next = ST_LOW;
                  tick_next = 8'h00;
               end else begin
                  sens_next = sens_reg + 16'h0001;
               end
            end
         end
         ST_LOW: begin
            if (tick_reg == 8'(SCK_HALF_CYC - 1)) begin
               tick_next = 8'h00;
               sck_next = 1'b1;
               state_next = ST_HIGH;
            end else begin
               tick_next = tick_reg + 8'h01;
            end
         end
         ST_HIGH: begin
            // Sample at the rising edge; the device only moves data after fall.
            if (tick_reg == 8'h00) begin
               shift_next = {shift_reg[14:0], misoSync_reg};
            end
            if (tick_reg == 8'(SCK_HALF_CYC - 1)) begin
               tick_next = 8'h00;
               sck_next = 1'b0;
               if (bit_reg == 5'(FRAME_BITS - 1)) begin
                  csN_next = 1'b1;
                  sample_next = shift_reg;
                  phys_next.tempCenti = temp_centi(shift_reg[7:0]);
                  phys_next.humidCenti = humid_centi(shift_reg[15:8],
                     temp_centi(shift_reg[7:0]));
                  valid_next = 1'b1;
                  state_next = ST_GAP;
                  sens_next = 16'h0000;
               end else begin
                  bit_next = bit_reg + 5'h01;
                  state_next = ST_LOW;
               end
            end else begin
               tick_next = tick_reg + 8'h01;
            end
         end
         ST_GAP: begin
            if (sensRise) begin
               if (sens_reg == 16'(CS_GAP_SENS)) begin
                  state_next = ST_IDLE;
               end else begin
                  sens_next = sens_reg + 16'h0001;
               end
            end
         end
         ST_PDHOLD: begin
            if (sensRise) begin
               if (sens_reg == 16'(PD_HOLD_SENS)) begin
                  state_next = ST_SLEEP;
               end else begin
                  sens_next = sens_reg + 16'h0001;
               end
            end
         end
         ST_SLEEP: begin
            if (!sleepReq) begin
               pd_next = 1'b0;
               state_next = ST_INIT;
               sens_next = 16'h0000;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg <= ST_INIT;
         sens_reg <= 16'h0000;
         tick_reg <= 8'h00;
         bit_reg <= 5'h00;
         shift_reg <= 16'h0000;
         sample_reg <= '0;
         phys_reg <= '0;
         valid_reg <= 1'b0;
         csN_reg <= 1'b1;
         sck_reg <= 1'b0;
         pd_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         sens_reg <= sens_next;
         tick_reg <= tick_next;
         bit_reg <= bit_next;
         shift_reg <= shift_next;
         sample_reg <= sample_next;
         phys_reg <= phys_next;
         valid_reg <= valid_next;
         csN_reg <= csN_next;
         sck_reg <= sck_next;
         pd_reg <= pd_next;
      end
   end

   // The last bit enters the shifter at the start of its high phase, so the
   // shifter is whole by the time the frame closes.
   assign sample = sample_reg;
   assign phys = phys_reg;
   assign sampleValid = valid_reg;
   assign ready = state_reg == ST_IDLE;
   assign busy = state_reg != ST_IDLE;
   assign asleep = state_reg == ST_SLEEP;
   assign pins = '{csN: csN_reg, sck: sck_reg, powerDownRequest: pd_reg,
      sensClk: sensClk};
endmodule : htr_host
`default_nettype wire

// ==== verif/htr_host_asserts.sv ====
// Port checker for the sensor readout host.
`timescale 1ns/100ps
`default_nettype none
module htr_host_asserts
   import htr_pkg::*;
#(
   parameter int INIT_CNT = 5
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Watched outputs
   input wire logic sampleValid,
   input wire htr_pkg::htr_sample_s sample,
   input wire htr_pkg::htr_phys_s phys,
   input wire logic asleep,
   input wire htr_pkg::htr_pins_s pins
);
   logic sensQ;
   logic sckQ;
   int setupCnt;
   int gapCnt;
   int wakeCnt;
   int pdCnt;
   int riseCnt;
   wire logic sRise = pins.sensClk & ~sensQ;
   wire logic kRise = pins.sck & ~sckQ;
   // Sensor clock and SCK rises are counted per phase of the pins.
   always_ff @(posedge clk_sys) begin
      sensQ <= rst ? 1'b0 : pins.sensClk;
      sckQ <= rst ? 1'b0 : pins.sck;
      setupCnt <= (rst | pins.csN) ? 0 : setupCnt + int'(sRise);
      gapCnt <= (rst | !pins.csN) ? 0 : gapCnt + int'(sRise);
      wakeCnt <= (rst | pins.powerDownRequest) ? 0 : wakeCnt + int'(sRise);
      pdCnt <= (rst | !pins.powerDownRequest) ? 0 : pdCnt + int'(sRise);
      riseCnt <= (rst | pins.csN) ? 0 : riseCnt + int'(kRise);
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sck_idle_a: assert property (pins.csN |-> !pins.sck)
      else $error("SCK active while deselected");
   sck_setup_a: assert property ($rose(pins.sck) |-> setupCnt >= 2)
      else $error("SCK edge too soon after select");
   sck_high_a: assert property ($rose(pins.sck) |-> pins.sck[*3])
      else $error("SCK high phase too short");
   sck_low_a: assert property ($fell(pins.sck) |-> !pins.sck[*3])
      else $error("SCK low phase too short");
   cs_gap_a: assert property ($fell(pins.csN) |-> gapCnt >= 3)
      else $error("Deselect gap too short");
   init_wait_a: assert property ($fell(pins.csN) |-> wakeCnt >= INIT_CNT)
      else $error("Access during wake-up");
   pd_clock_a: assert property ($rose(asleep) |-> pdCnt >= 16)
      else $error("Sensor clock stopped too early");
   pd_desel_a: assert property (pins.powerDownRequest |-> pins.csN)
      else $error("Select while powered down");
   frame_len_a: assert property ($rose(pins.csN) |-> riseCnt == 16)
      else $error("Frame not sixteen clocks");
   sample_upd_a: assert property ($changed(sample) |-> sampleValid)
      else $error("Sample changed without valid");
   phys_upd_a: assert property ($changed(phys) |-> sampleValid)
      else $error("Converted value changed without valid");
   cover property ($rose(sampleValid));
   cover property ($rose(asleep));
   cover property ($fell(pins.powerDownRequest));
endmodule : htr_host_asserts
`default_nettype wire

// ==== verif/htr_sensor_model.sv ====
// Behavioural model of the humidity and temperature sensor.
`timescale 1ns/100ps
`default_nettype none
module htr_sensor_model #(
   parameter int INIT = 5,
   parameter int REFRESH = 512
) (
   // Pins from the host
   input wire logic csN,
   input wire logic sck,
   input wire logic powerDownRequest,
   input wire logic sensClk,
   // Bench side
   input wire logic [15:0] value,
   output logic miso,
   output logic initViol
);
   logic [15:0] shiftReg = 16'h0000;
   int initCnt = INIT;
   int selCnt = 0;
   logic [15:0] result = 16'h0000;
   int refreshCnt = 0;
   initial miso = 1'b0;
   initial initViol = 1'b0;
   // Power-down resets the device; release restarts its init count.
   always @(posedge sensClk or posedge powerDownRequest) begin
      if (powerDownRequest) begin
         initCnt <= INIT;
         refreshCnt <= 0;
      end else begin
         if (initCnt > 0) initCnt <= initCnt - 1;
         // Results refresh on a fixed sensor clock beat.
         if (refreshCnt == REFRESH - 1) begin
            refreshCnt <= 0;
            result <= value;
         end else begin
            refreshCnt <= refreshCnt + 1;
         end
      end
   end
   always @(negedge csN) begin
      initViol = initViol | (initCnt != 0);
      shiftReg = result;
      selCnt = 0;
      miso = ~value[15];
   end
   always @(posedge sensClk) if (!csN && selCnt < 3) begin
      selCnt = selCnt + 1;
      if (selCnt == 3) miso = shiftReg[15];
   end
   always @(negedge sck) if (!csN) begin
      shiftReg = {shiftReg[14:0], 1'b0};
      miso = shiftReg[15];
   end
   // The line inverts when deselected, so it shows no stale bit.
   always @(posedge csN) miso = ~miso;
endmodule : htr_sensor_model
`default_nettype wire

// ==== verif/tb_humidity_temp_spi_readout.sv ====
// Self-checking bench for the humidity and temperature readout host.
`timescale 1ns/100ps
`default_nettype none
module tb_humidity_temp_spi_readout;
   import htr_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic readReq = 1'b0;
   logic sleepReq = 1'b0;
   logic busy, ready, sampleValid, asleep, miso, initViol;
   htr_sample_s sample;
   htr_phys_s phys;
   htr_pins_s pins;
   logic [15:0] value = 16'h0000;
   int err_total = 0;
   int checked = 0;

   initial forever #20 clk_sys = ~clk_sys;

   htr_host #(.SENS_HALF(4), .INIT_CNT(5)) u_dut (.clk_sys(clk_sys),
      .rst(rst), .readReq(readReq), .sleepReq(sleepReq), .busy(busy),
      .ready(ready), .sampleValid(sampleValid), .sample(sample),
      .asleep(asleep), .pins(pins), .miso(miso), .phys(phys));
   htr_sensor_model #(.INIT(5)) u_sensor (.csN(pins.csN), .sck(pins.sck),
      .powerDownRequest(pins.powerDownRequest), .sensClk(pins.sensClk),
      .value(value), .miso(miso), .initViol(initViol));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp,
         input string what);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wrap_up();
      $display("checked=%0d err_total=%0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up

   // The sensor value is changed just after select, before the first SCK, to prove it was captured.
   task automatic read_once(input logic [15:0] v);
      int n;
      real s;
      real t;
      real h;
      int dt;
      int dh;
      value = v;
      // Let the sensor pass one refresh so that it reports the new value.
      repeat (4400) @(negedge clk_sys);
      n = 0;
      while (ready !== 1'b1 && n < 2000) begin
         @(negedge clk_sys);
         n++;
      end
      check(16'(n < 2000), 16'h0001, "ready");
      readReq = 1'b1;
      @(negedge clk_sys);
      readReq = 1'b0;
      value = ~v;
      n = 0;
      while (sampleValid !== 1'b1 && n < 400) begin
         @(negedge clk_sys);
         n++;
      end
      check(16'(n < 400), 16'h0001, "done");
      check(sample, v, "sample");
      s = real'(v[15:8]);
      t = real'(v[7:0]) / 2.55 - 20.0;
      h = -12.84 + 0.68 * s - 0.0007981 * s * s
         + (t - 25.0) * (0.01 + 0.00075 * s);
      dt = int'(signed'(phys.tempCenti)) - $rtoi(t * 100.0);
      dh = int'(signed'(phys.humidCenti)) - $rtoi(h * 100.0);
      check(16'($isunknown(phys)), 16'h0000, "converted known");
      check(16'(dt >= -2 && dt <= 2), 16'h0001, "temperature");
      check(16'(dh >= -2 && dh <= 2), 16'h0001, "humidity");
      $display("read %h finished", v);
   endtask : read_once

   task automatic sleep_wake();
      int n;
      sleepReq = 1'b1;
      n = 0;
      while (asleep !== 1'b1 && n < 1000) begin
         @(negedge clk_sys);
         n++;
      end
      check(16'({asleep, pins.powerDownRequest}), 16'h0003, "power down");
      readReq = 1'b1;
      repeat (40) @(negedge clk_sys);
      check(16'({pins.csN, ready}), 16'h0002, "refused");
      readReq = 1'b0;
      sleepReq = 1'b0;
      read_once(16'h1234);
      check(16'(initViol), 16'h0000, "wake access");
      $display("sleep and wake finished");
   endtask : sleep_wake

   initial begin
      repeat (12) @(negedge clk_sys);
      rst = 1'b0;
      @(negedge clk_sys);
      check(16'(busy), 16'h0001, "init busy");
      read_once(16'hA53C);
      read_once(16'h5AC3);
      read_once(16'h00FF);
      read_once(16'hFF00);
      sleep_wake();
      wrap_up();
   end

   initial begin
      #(40 * 40000);
      err_total++;
      wrap_up();
   end
endmodule : tb_humidity_temp_spi_readout

bind htr_host htr_host_asserts #(.INIT_CNT(INIT_CNT)) u_chk (
   .clk_sys(clk_sys), .rst(rst), .sampleValid(sampleValid),
   .sample(sample), .phys(phys), .asleep(asleep), .pins(pins));
`default_nettype wire
